//--- logic/pvn_bank.sv
// Peripheral vector number register bank with Avalon-MM slave and vector lookup.
// Assumes a single 20 MHz clock; standby is an input that only gates nothing.
module pvn_bank
  import pvn_pkg::*;
(
  input wire logic clk, // System clock, 20 MHz.
  input wire logic arst_n, // Asynchronous reset, active low.
  input wire logic [7:0] avs_address, // Byte address.
  input wire logic avs_read, // Read request.
  input wire logic avs_write, // Write request.
  input wire logic [31:0] avs_writedata, // Write data.
  input wire logic [3:0] avs_byteenable, // Byte enables.
  output logic [31:0] avs_readdata, // Read data, registered.
  output logic avs_waitrequest, // Wait request.
  input wire logic standby, // Standby mode indication.
  input wire logic irq_accept, // Controller accepts a source.
  input wire logic [3:0] irq_src, // Accepted source code.
  output logic [6:0] irq_vector, // Vector number for accepted source.
  output logic irq_vector_valid // Vector valid, one-cycle pulse.
);
  typedef struct packed {
    pvn_bank_t bank;
    logic [3:0] srcsel;
    logic [31:0] rdata;
    logic ack;
  } pvn_state_t;
  pvn_state_t st_reg, st_next;
  pvn_vec_if vif ();

  // Writes are masked per register so reserved positions can never hold a one.
  function automatic logic [15:0] pvn_wr(input logic [15:0] old, input logic [31:0] d,
                                         input logic [3:0] be, input logic [15:0] mask);
    logic [15:0] v;
    v = old;
    if (be[0]) begin
      v[7:0] = d[7:0];
    end
    if (be[1]) begin
      v[15:8] = d[15:8];
    end
    return v & mask;
  endfunction

  logic req;
  logic wdone;
  logic [6:0] lookup_vec;
  assign req = (avs_read || avs_write) && !st_reg.ack;
  // A write lands in its second cycle, where waitrequest is low and the request still stands.
  assign wdone = avs_write && st_reg.ack;

  always_comb begin
    st_next = st_reg;
    st_next.ack = req;
    if (wdone) begin
      case (avs_address)
        `PVN_OFS_ETHER: st_next.bank.ether_dma_vector = pvn_wr(st_reg.bank.ether_dma_vector,
          avs_writedata, avs_byteenable, `PVN_MASK_ONE);
        `PVN_OFS_FRCC: st_next.bank.free_run_capture_compare_vector = pvn_wr(
          st_reg.bank.free_run_capture_compare_vector, avs_writedata, avs_byteenable,
          `PVN_MASK_TWO);
        `PVN_OFS_FROV: st_next.bank.free_run_overflow_vector = pvn_wr(
          st_reg.bank.free_run_overflow_vector, avs_writedata, avs_byteenable,
          `PVN_MASK_ONE);
        `PVN_OFS_P0AB: st_next.bank.pulse0_ab_match_vector = pvn_wr(
          st_reg.bank.pulse0_ab_match_vector, avs_writedata, avs_byteenable,
          `PVN_MASK_TWO);
        `PVN_OFS_P0CD: st_next.bank.pulse0_cd_match_vector = pvn_wr(
          st_reg.bank.pulse0_cd_match_vector, avs_writedata, avs_byteenable,
          `PVN_MASK_TWO);
        `PVN_OFS_P0OV: st_next.bank.pulse0_overflow_vector = pvn_wr(
          st_reg.bank.pulse0_overflow_vector, avs_writedata, avs_byteenable,
          `PVN_MASK_ONE);
        `PVN_OFS_SRCSEL: begin
          if (avs_byteenable[0]) begin
            st_next.srcsel = avs_writedata[3:0];
          end
        end
        default: st_next.srcsel = st_reg.srcsel;
      endcase
    end
    if (req && avs_read) begin
      // The reserved slot is never written, so it reads its reset zero.
      case (avs_address)
        `PVN_OFS_ETHER: st_next.rdata = {16'h0000, st_reg.bank.ether_dma_vector};
        `PVN_OFS_RSVD: st_next.rdata = {16'h0000, st_reg.bank.reserved_vector_slot};
        `PVN_OFS_FRCC: st_next.rdata = {16'h0000, st_reg.bank.free_run_capture_compare_vector};
        `PVN_OFS_FROV: st_next.rdata = {16'h0000, st_reg.bank.free_run_overflow_vector};
        `PVN_OFS_P0AB: st_next.rdata = {16'h0000, st_reg.bank.pulse0_ab_match_vector};
        `PVN_OFS_P0CD: st_next.rdata = {16'h0000, st_reg.bank.pulse0_cd_match_vector};
        `PVN_OFS_P0OV: st_next.rdata = {16'h0000, st_reg.bank.pulse0_overflow_vector};
        `PVN_OFS_SRCSEL: st_next.rdata = {28'h0000000, st_reg.srcsel};
        `PVN_OFS_CURVEC: st_next.rdata = {25'h0000000, lookup_vec};
        default: st_next.rdata = 32'h00000000;
      endcase
    end
  end

  // Standby is deliberately absent from the update path so vectors survive it.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  // Software readback of the vector for a selected source uses the same source-to-field mapping as pvn_pick in pvn_vec_select.
  always_comb begin
    unique case (st_reg.srcsel)
      PVN_SRC_ETHER: lookup_vec = st_reg.bank.ether_dma_vector[14:8];
      PVN_SRC_CAPTURE: lookup_vec = st_reg.bank.free_run_capture_compare_vector[14:8];
      PVN_SRC_COMPARE: lookup_vec = st_reg.bank.free_run_capture_compare_vector[6:0];
      PVN_SRC_FROVF: lookup_vec = st_reg.bank.free_run_overflow_vector[14:8];
      PVN_SRC_P0A: lookup_vec = st_reg.bank.pulse0_ab_match_vector[14:8];
      PVN_SRC_P0B: lookup_vec = st_reg.bank.pulse0_ab_match_vector[6:0];
      PVN_SRC_P0C: lookup_vec = st_reg.bank.pulse0_cd_match_vector[14:8];
      PVN_SRC_P0D: lookup_vec = st_reg.bank.pulse0_cd_match_vector[6:0];
      PVN_SRC_P0OVF: lookup_vec = st_reg.bank.pulse0_overflow_vector[14:8];
      default: lookup_vec = 7'h00;
    endcase
  end

  assign vif.bank = st_reg.bank;
  assign avs_readdata = st_reg.rdata;
  assign avs_waitrequest = (avs_read || avs_write) && !st_reg.ack;

  pvn_vec_select u_sel (
    .clk(clk),
    .arst_n(arst_n),
    .vif(vif),
    .accept(irq_accept),
    .src(irq_src),
    .vec(irq_vector),
    .vec_valid(irq_vector_valid)
  );

  // A write lands at the edge where waitrequest is seen low, in the request's second cycle.
  sequence s_write_hi(logic [7:0] a);
    avs_write && !avs_waitrequest && avs_address == a && avs_byteenable[1];
  endsequence

  sequence s_write_lo(logic [7:0] a);
    avs_write && !avs_waitrequest && avs_address == a && avs_byteenable[0];
  endsequence

  // A read is decoded in its first cycle; its data stands at the completion edge.
  sequence s_read_start(logic [7:0] a);
    avs_read && avs_waitrequest && avs_address == a;
  endsequence

  chk_ether_field_write: assert property (@(posedge clk) disable iff (!arst_n)
    s_write_hi(`PVN_OFS_ETHER) |=>
    st_reg.bank.ether_dma_vector == {1'b0, $past(avs_writedata[14:8]), 8'h00})
    else $error("ethernet vector write not stored in bits 14 to 8");

  chk_ether_low_zero: assert property (@(posedge clk) disable iff (!arst_n)
    s_write_lo(`PVN_OFS_ETHER) |=> st_reg.bank.ether_dma_vector[7:0] == 8'h00)
    else $error("ethernet vector low byte not zero");

  chk_reserved_zero: assert property (@(posedge clk) disable iff (!arst_n)
    (st_reg.bank.ether_dma_vector & ~`PVN_MASK_ONE) == 16'h0000 &&
    (st_reg.bank.free_run_overflow_vector & ~`PVN_MASK_ONE) == 16'h0000 &&
    (st_reg.bank.pulse0_overflow_vector & ~`PVN_MASK_ONE) == 16'h0000 &&
    (st_reg.bank.pulse0_ab_match_vector & ~`PVN_MASK_TWO) == 16'h0000)
    else $error("reserved bit holds a one");

  chk_reserved_pair_zero: assert property (@(posedge clk) disable iff (!arst_n)
    (st_reg.bank.free_run_capture_compare_vector & ~`PVN_MASK_TWO) == 16'h0000 &&
    (st_reg.bank.pulse0_cd_match_vector & ~`PVN_MASK_TWO) == 16'h0000)
    else $error("reserved bit of a paired register holds a one");

  chk_readdata_upper: assert property (@(posedge clk) disable iff (!arst_n)
    avs_readdata[31:16] == 16'h0000)
    else $error("upper read data lanes not zero");

  // Addresses past the decoded range answer zero so a stray read never sees stale data.
  chk_unmapped_read_zero: assert property (@(posedge clk) disable iff (!arst_n)
    avs_read && avs_waitrequest && avs_address > `PVN_OFS_CURVEC |=> avs_readdata == 32'h0)
    else $error("unmapped address did not read zero");

  chk_reset_clear: assert property (@(posedge clk)
    $rose(arst_n) |-> st_reg.bank == '0)
    else $error("bank not clear after reset");

  chk_reset_outputs: assert property (@(posedge clk)
    $rose(arst_n) |-> avs_readdata == 32'h0 && !irq_vector_valid && st_reg.srcsel == 4'h0)
    else $error("outputs not clear after reset");

  chk_standby_hold: assert property (@(posedge clk) disable iff (!arst_n)
    $changed(standby) && !avs_write |=> $stable(st_reg.bank))
    else $error("standby changed a vector");

  // Only a completed write may move the bank, whatever standby or the vector port do.
  chk_bank_idle_hold: assert property (@(posedge clk) disable iff (!arst_n)
    !(avs_write && !avs_waitrequest) |=> $stable(st_reg.bank))
    else $error("bank moved without a completed write");

  chk_rsvd_slot_zero: assert property (@(posedge clk) disable iff (!arst_n)
    st_reg.bank.reserved_vector_slot == 16'h0000)
    else $error("reserved slot not zero");

  chk_capture_write: assert property (@(posedge clk) disable iff (!arst_n)
    s_write_hi(`PVN_OFS_FRCC) |=>
    st_reg.bank.free_run_capture_compare_vector[14:8] == $past(avs_writedata[14:8]))
    else $error("capture vector not stored");

  chk_compare_low: assert property (@(posedge clk) disable iff (!arst_n)
    avs_write && !avs_waitrequest && avs_address == `PVN_OFS_FRCC && avs_byteenable == 4'h3
    |=> st_reg.bank.free_run_capture_compare_vector == ($past(avs_writedata[15:0]) & 16'h7f7f))
    else $error("capture or compare field wrong");

  chk_compare_write: assert property (@(posedge clk) disable iff (!arst_n)
    s_write_lo(`PVN_OFS_FRCC) |=>
    st_reg.bank.free_run_capture_compare_vector[7:0] == {1'b0, $past(avs_writedata[6:0])})
    else $error("compare vector not stored or bit 7 set");

  chk_frovf_low_byte: assert property (@(posedge clk) disable iff (!arst_n)
    st_reg.bank.free_run_overflow_vector[7:0] == 8'h00)
    else $error("overflow low byte not zero");

  chk_frovf_write: assert property (@(posedge clk) disable iff (!arst_n)
    s_write_hi(`PVN_OFS_FROV) |=>
    st_reg.bank.free_run_overflow_vector == {1'b0, $past(avs_writedata[14:8]), 8'h00})
    else $error("free-run overflow vector not stored");

  chk_p0a_write: assert property (@(posedge clk) disable iff (!arst_n)
    s_write_hi(`PVN_OFS_P0AB) |=>
    st_reg.bank.pulse0_ab_match_vector[14:8] == $past(avs_writedata[14:8]))
    else $error("pulse unit A vector not stored");

  chk_p0b_write: assert property (@(posedge clk) disable iff (!arst_n)
    s_write_lo(`PVN_OFS_P0AB) |=>
    st_reg.bank.pulse0_ab_match_vector[7:0] == {1'b0, $past(avs_writedata[6:0])})
    else $error("pulse unit B vector not stored");

  chk_p0c_write: assert property (@(posedge clk) disable iff (!arst_n)
    s_write_hi(`PVN_OFS_P0CD) |=>
    st_reg.bank.pulse0_cd_match_vector[14:8] == $past(avs_writedata[14:8]))
    else $error("pulse unit C vector not stored");

  chk_p0d_write: assert property (@(posedge clk) disable iff (!arst_n)
    s_write_lo(`PVN_OFS_P0CD) |=>
    st_reg.bank.pulse0_cd_match_vector[7:0] == {1'b0, $past(avs_writedata[6:0])})
    else $error("pulse unit D vector not stored");

  chk_p0ovf_write: assert property (@(posedge clk) disable iff (!arst_n)
    s_write_hi(`PVN_OFS_P0OV) |=>
    st_reg.bank.pulse0_overflow_vector == {1'b0, $past(avs_writedata[14:8]), 8'h00})
    else $error("pulse unit overflow vector not stored");

  chk_read_ether: assert property (@(posedge clk) disable iff (!arst_n)
    s_read_start(`PVN_OFS_ETHER) |=>
    avs_readdata == {16'h0000, $past(st_reg.bank.ether_dma_vector)})
    else $error("ethernet vector read back wrong");

  chk_read_frcc: assert property (@(posedge clk) disable iff (!arst_n)
    s_read_start(`PVN_OFS_FRCC) |=>
    avs_readdata == {16'h0000, $past(st_reg.bank.free_run_capture_compare_vector)})
    else $error("capture and compare vectors read back wrong");

  chk_read_frov: assert property (@(posedge clk) disable iff (!arst_n)
    s_read_start(`PVN_OFS_FROV) |=>
    avs_readdata == {16'h0000, $past(st_reg.bank.free_run_overflow_vector)})
    else $error("free-run overflow vector read back wrong");

  chk_read_p0ab: assert property (@(posedge clk) disable iff (!arst_n)
    s_read_start(`PVN_OFS_P0AB) |=>
    avs_readdata == {16'h0000, $past(st_reg.bank.pulse0_ab_match_vector)})
    else $error("pulse unit A and B vectors read back wrong");

  chk_read_p0cd: assert property (@(posedge clk) disable iff (!arst_n)
    s_read_start(`PVN_OFS_P0CD) |=>
    avs_readdata == {16'h0000, $past(st_reg.bank.pulse0_cd_match_vector)})
    else $error("pulse unit C and D vectors read back wrong");

  chk_read_p0ov: assert property (@(posedge clk) disable iff (!arst_n)
    s_read_start(`PVN_OFS_P0OV) |=>
    avs_readdata == {16'h0000, $past(st_reg.bank.pulse0_overflow_vector)})
    else $error("pulse unit overflow vector read back wrong");

  chk_read_answer: assert property (@(posedge clk) disable iff (!arst_n)
    avs_read && avs_waitrequest |=> !avs_waitrequest)
    else $error("read not answered in one cycle");

  chk_write_answer: assert property (@(posedge clk) disable iff (!arst_n)
    avs_write && avs_waitrequest |=> !avs_waitrequest)
    else $error("write not answered in one cycle");

  chk_vector_holds: assert property (@(posedge clk) disable iff (!arst_n)
    !irq_accept |=> $stable(irq_vector))
    else $error("vector number changed without an accept");

  chk_valid_pulse: assert property (@(posedge clk) disable iff (!arst_n)
    !irq_accept |=> !irq_vector_valid)
    else $error("vector valid without an accept");

endmodule

//--- pkg/pvn_regs.svh
// Register offsets, field positions and reset values of the peripheral vector bank.
// Assumes inclusion by its bare name from the package and the test bench.
`ifndef PVN_REGS_SVH
`define PVN_REGS_SVH
`define PVN_OFS_ETHER 8'h00
`define PVN_OFS_RSVD 8'h04
`define PVN_OFS_FRCC 8'h08
`define PVN_OFS_FROV 8'h0c
`define PVN_OFS_P0AB 8'h10
`define PVN_OFS_P0CD 8'h14
`define PVN_OFS_P0OV 8'h18
`define PVN_OFS_SRCSEL 8'h1c
`define PVN_OFS_CURVEC 8'h20
`define PVN_HI_LSB 8
`define PVN_LO_LSB 0
`define PVN_RESET_VAL 16'h0000
`define PVN_MASK_TWO 16'h7f7f
`define PVN_MASK_ONE 16'h7f00
`endif

//--- pkg/pvn_pkg.sv
// Types shared by the peripheral vector bank modules.
// Assumes pvn_regs.svh is on the include path.
package pvn_pkg;
  `include "pvn_regs.svh"
  typedef logic [6:0] pvn_vec_t;
  typedef enum logic [3:0] {
    PVN_SRC_ETHER,
    PVN_SRC_CAPTURE,
    PVN_SRC_COMPARE,
    PVN_SRC_FROVF,
    PVN_SRC_P0A,
    PVN_SRC_P0B,
    PVN_SRC_P0C,
    PVN_SRC_P0D,
    PVN_SRC_P0OVF
  } pvn_src_t;
  typedef struct packed {
    logic [15:0] ether_dma_vector;
    logic [15:0] reserved_vector_slot;
    logic [15:0] free_run_capture_compare_vector;
    logic [15:0] free_run_overflow_vector;
    logic [15:0] pulse0_ab_match_vector;
    logic [15:0] pulse0_cd_match_vector;
    logic [15:0] pulse0_overflow_vector;
  } pvn_bank_t;
endpackage

//--- pkg/pvn_vec_if.sv
// Carries the programmed bank from the register slave to the vector selector.
// Assumes both ends run on the same clock.
interface pvn_vec_if;
  import pvn_pkg::*;
  pvn_bank_t bank;
  modport src (output bank);
  modport dst (input bank);
endinterface

//--- logic/pvn_vec_select.sv
// Returns the vector number programmed for an accepted interrupt source.
// Assumes the source code is stable while accept is high.
module pvn_vec_select
  import pvn_pkg::*;
(
  input wire logic clk, // System clock.
  input wire logic arst_n, // Asynchronous reset, active low.
  pvn_vec_if.dst vif, // Programmed bank.
  input wire logic accept, // Controller accepts a source.
  input wire logic [3:0] src, // Accepted source code.
  output logic [6:0] vec, // Vector number, registered.
  output logic vec_valid // Vector number valid, one-cycle pulse.
);
  typedef struct packed {
    logic [6:0] vec;
    logic valid;
  } pvn_sel_state_t;
  pvn_sel_state_t st_reg, st_next;

  function automatic pvn_vec_t pvn_pick(input pvn_bank_t b, input logic [3:0] s);
    pvn_vec_t v;
    v = 7'h00;
    case (s)
      PVN_SRC_ETHER: v = b.ether_dma_vector[`PVN_HI_LSB +: 7];
      PVN_SRC_CAPTURE: v = b.free_run_capture_compare_vector[`PVN_HI_LSB +: 7];
      PVN_SRC_COMPARE: v = b.free_run_capture_compare_vector[`PVN_LO_LSB +: 7];
      PVN_SRC_FROVF: v = b.free_run_overflow_vector[`PVN_HI_LSB +: 7];
      PVN_SRC_P0A: v = b.pulse0_ab_match_vector[`PVN_HI_LSB +: 7];
      PVN_SRC_P0B: v = b.pulse0_ab_match_vector[`PVN_LO_LSB +: 7];
      PVN_SRC_P0C: v = b.pulse0_cd_match_vector[`PVN_HI_LSB +: 7];
      PVN_SRC_P0D: v = b.pulse0_cd_match_vector[`PVN_LO_LSB +: 7];
      PVN_SRC_P0OVF: v = b.pulse0_overflow_vector[`PVN_HI_LSB +: 7];
      default: v = 7'h00;
    endcase
    return v;
  endfunction

  always_comb begin
    st_next = st_reg;
    st_next.valid = accept;
    if (accept) begin
      st_next.vec = pvn_pick(vif.bank, src);
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign vec = st_reg.vec;
  assign vec_valid = st_reg.valid;

  chk_vec_follows_accept: assert property (@(posedge clk) disable iff (!arst_n)
    accept |=> vec_valid && vec == $past(pvn_pick(vif.bank, src)))
    else $error("vector number does not match accepted source");
endmodule

//--- verif/pvn_bank_test.sv
// Self-checking bench for the peripheral vector number register bank.
// Assumes pvn_pkg, pvn_vec_if, pvn_vec_select and pvn_bank are compiled first.
`include "pvn_regs.svh"
module pvn_bank_test
  import pvn_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk, arst_n, avs_read, avs_write, avs_waitrequest, standby, irq_accept, irq_vector_valid;
  logic [7:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata, v;
  logic [3:0] avs_byteenable, irq_src;
  logic [6:0] irq_vector;
  int fail_count, num_checks;
  logic [7:0] ofs [7] = '{`PVN_OFS_ETHER, `PVN_OFS_RSVD, `PVN_OFS_FRCC, `PVN_OFS_FROV,
                          `PVN_OFS_P0AB, `PVN_OFS_P0CD, `PVN_OFS_P0OV};
  logic [15:0] msk [7] = '{16'h7f00, 16'h0000, 16'h7f7f, 16'h7f00, 16'h7f7f, 16'h7f7f, 16'h7f00};
  logic [15:0] pat [7] = '{16'h7f00, 16'h0000, 16'h552a, 16'h0100, 16'h1234, 16'h5678, 16'h4000};
  logic [6:0] vexp [10] = '{7'h7f, 7'h55, 7'h2a, 7'h01, 7'h12, 7'h34, 7'h56, 7'h78, 7'h40, 7'h00};

  pvn_bank i_pvn_bank (.clk(clk), .arst_n(arst_n), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .standby(standby), .irq_accept(irq_accept),
    .irq_src(irq_src), .irq_vector(irq_vector), .irq_vector_valid(irq_vector_valid));

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("wrong value at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask

  // The request is held until the rising edge at which waitrequest stands low, for at most 50
  // cycles. Waitrequest and read data are settled by mid-cycle and stand through that edge.
  task automatic bus(input logic is_wr, input logic [7:0] a, input logic [15:0] d,
                     output logic [31:0] q);
    int n;
    logic done;
    n = 0;
    done = 1'b0;
    q = 32'h0;
    @(posedge clk);
    avs_address <= a;
    avs_write <= is_wr;
    avs_read <= !is_wr;
    avs_writedata <= {16'h0000, d};
    do begin
      @(negedge clk);
      n++;
      done = (avs_waitrequest === 1'b0);
      q = avs_readdata;
      @(posedge clk);
    end while (!done && n < 50);
    if (!done) check(32'h1, 32'h0);
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    logic [31:0] dummy;
    bus(1'b1, a, d, dummy);
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] q);
    bus(1'b0, a, 16'h0000, q);
  endtask

  task automatic acc(input logic [3:0] s, input logic [6:0] exp);
    @(posedge clk);
    irq_accept <= 1'b1;
    irq_src <= s;
    @(posedge clk);
    irq_accept <= 1'b0;
    @(negedge clk);
    check({24'h0, irq_vector_valid, irq_vector}, {24'h0, 1'b1, exp});
    @(negedge clk);
    check({31'h0, irq_vector_valid}, 32'h0);
  endtask

  task automatic test_reset_vals;
    for (int i = 0; i < 7; i++) begin
      if (i == 1) continue;
      rd(ofs[i], v);
      check(v, 32'h0);
    end
    $display("reset values done");
  endtask

  // Only field bits are written to the registers: software gives reserved positions zero.
  task automatic test_masks;
    for (int i = 0; i < 7; i++) begin
      if (i == 1) continue;
      wr(ofs[i], msk[i]);
      rd(ofs[i], v);
      check(v, {16'h0000, msk[i]});
    end
    wr(8'h3c, 16'hffff);
    rd(8'h3c, v);
    check(v, 32'h0);
    $display("field masks done");
  endtask

  task automatic test_fields;
    for (int i = 0; i < 7; i++) begin
      if (i == 1) continue;
      wr(ofs[i], pat[i]);
      rd(ofs[i], v);
      check(v, {16'h0000, pat[i]});
    end
    for (int s = 0; s < 10; s++) acc(s[3:0], vexp[s]);
    wr(`PVN_OFS_SRCSEL, 16'h0004);
    rd(`PVN_OFS_CURVEC, v);
    check(v, 32'h12);
    $display("vector lookup done");
  endtask

  // Storage must ride through standby both while it is asserted and after.
  task automatic test_standby;
    for (int p = 0; p < 2; p++) begin
      @(posedge clk);
      standby <= (p == 0);
      repeat (4) @(posedge clk);
      for (int i = 0; i < 7; i++) begin
        if (i == 1) continue;
        rd(ofs[i], v);
        check(v, {16'h0000, pat[i]});
      end
    end
    acc(4'h7, 7'h78);
    $display("standby done");
  endtask

  task automatic test_mid_reset;
    @(posedge clk);
    arst_n <= 1'b0;
    repeat (2) @(posedge clk);
    arst_n <= 1'b1;
    for (int i = 0; i < 7; i++) begin
      if (i == 1) continue;
      rd(ofs[i], v);
      check(v, 32'h0);
    end
    acc(4'h0, 7'h00);
    $display("mid-run reset done");
  endtask

  task automatic conclude;
    $display("checks %0d, mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  initial begin
    arst_n = 1'b0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_address = 8'h00;
    avs_writedata = 32'h0;
    avs_byteenable = 4'h3;
    standby = 1'b0;
    irq_accept = 1'b0;
    irq_src = 4'h0;
    repeat (8) @(posedge clk);
    arst_n <= 1'b1;
    test_reset_vals();
    test_masks();
    test_fields();
    test_standby();
    test_mid_reset();
    conclude();
  end

  // The whole run needs well under a thousand cycles; this allows five thousand.
  initial begin
    #250000;
    fail_count++;
    conclude();
  end
endmodule
